// File: adcrc_pkg.sv
// Shared constants and types for the converter result and clock control
package adcrc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_RESULT_HIGH    = 8'h04;
  localparam logic [7:0] OFS_RESULT_LOW     = 8'h08;
  localparam logic [7:0] OFS_CLOCK_MODE     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h14;
  // Status and control fields
  localparam int SCR_DONE_BIT = 7;
  localparam int SCR_AIEN_BIT = 6;
  localparam int SCR_CONT_BIT = 5;
  localparam int SCR_CHAN_LSB = 0;
  // Clock and mode fields
  localparam int CLK_LPC_BIT  = 7;
  localparam int CLK_DIV_LSB  = 5;
  localparam int CLK_ICS_BIT  = 4;
  localparam int CLK_MODE_LSB = 2;
  localparam int CLK_LSMP_BIT = 1;
  localparam int CLK_ACLK_BIT = 0;
  // Reset values, channel off code and mode encodings
  localparam logic [4:0] CHAN_OFF       = 5'h1F;
  localparam logic [4:0] RST_CHAN       = 5'h1F;
  localparam logic [1:0] RST_DIV        = 2'h0;
  localparam logic [1:0] MODE_8_SW      = 2'h0;
  localparam logic [1:0] MODE_10_SW     = 2'h1;
  localparam logic [1:0] MODE_10_HW     = 2'h3;
  localparam logic [1:0] RST_MODE       = 2'h0;
  // Timing in conversion clock half periods
  localparam logic [5:0] SAMPLE_SHORT_HALF = 6'h07; // 3.5 cycles
  localparam logic [5:0] SAMPLE_LONG_HALF  = 6'h2F; // 23.5 cycles
  localparam logic [5:0] CONVERT_HALF      = 6'h14; // 10 cycles
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_CONVERT
  } adcrc_state_e;
endpackage

// File: adcrc_sync.sv
// Two flop synchronizer for inputs from outside the bus clock domain
`timescale 1ns/100ps
`default_nettype none
module adcrc_sync #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } adcrc_sync_s;

  adcrc_sync_s st_q;
  adcrc_sync_s st_d;

  // Second stage is the only reader of the first
  always_comb begin
    st_d.meta = d;
    st_d.sync = st_q.meta;
  end

  // Register the chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.sync;
endmodule
`default_nettype wire

// File: adcrc_divider.sv
// Conversion clock divider working on input clock half period ticks
`timescale 1ns/100ps
`default_nettype none
module adcrc_divider (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       in_tick,
  input  wire logic [1:0] ratio_code,
  input  wire logic       restart,
  // Outputs
  output logic            half_tick,
  output logic            conv_clk
);
  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
    logic       clk;
  } adcrc_div_s;

  adcrc_div_s st_q;
  adcrc_div_s st_d;
  logic [2:0] last;

  // divide ratio 1 2 4 8
  always_comb begin
    last      = 3'((4'h1 << ratio_code) - 4'h1);
    st_d      = st_q;
    st_d.tick = 1'b0;
    // A restart edge that is also an input edge counts as the first
    // half period, so the sample phase is not stretched by one cycle
    if (restart) begin
      st_d.cnt = '0;
      st_d.clk = 1'b0;
      if (in_tick && last == 3'h0) begin
        st_d.tick = 1'b1;
        st_d.clk  = 1'b1;
      end else if (in_tick) begin
        st_d.cnt = 3'h1;
      end
    end else if (in_tick) begin
      if (st_q.cnt == last) begin
        st_d.cnt  = '0;
        st_d.tick = 1'b1;
        st_d.clk  = ~st_q.clk;
      end else begin
        st_d.cnt = st_q.cnt + 3'h1;
      end
    end
  end

  // Restart aligns the clock phase with the sample start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign half_tick = st_q.tick;
  assign conv_clk  = st_q.clk;

  // tick only after full ratio count
  a_div_ratio: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_q.tick) |-> $past(st_q.cnt) == $past(last))
    else $error("divider tick before ratio reached");
endmodule
`default_nettype wire

// File: adcrc_top.sv
// Converter result registers, clock and mode control, APB slave
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module adcrc_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // System and pins
  input  wire logic        stop_mode,
  input  wire logic        hw_trigger,
  input  wire logic        alt_clk,
  input  wire logic        async_clk,
  // Analog core
  input  wire logic [9:0]  core_result,
  output logic      [4:0]  core_channel,
  output logic             core_sample,
  output logic             core_convert,
  output logic             core_low_power,
  output logic             core_ten_bit,
  output logic             async_osc_en,
  output logic             conv_clk,
  // Interrupt
  output logic             irq
);
  typedef struct packed {
    logic                  aien;
    logic                  cont;
    logic [4:0]            chan;
    logic                  done;
    logic                  lpc;
    logic [1:0]            div;
    logic                  ics;
    logic [1:0]            mode;
    logic                  lsmp;
    logic                  aclk;
    logic [1:0]            res_hi;
    logic [7:0]            res_lo;
    logic                  locked;
    logic                  irq_stat;
    logic                  irq_mask;
    adcrc_pkg::adcrc_state_e state;
    logic [5:0]            cnt;
    logic [31:0]           rdata;
    logic                  ready;
    logic                  err;
    logic [2:0]            pins_d;
    logic                  sample;
    logic                  convert;
    logic                  osc_en;
    logic                  irq;
    logic                  ten;
  } adcrc_top_s;

  adcrc_top_s st_q;
  adcrc_top_s st_d;
  logic [2:0] pins_s;
  logic       half_tick;
  logic       in_tick;
  logic       restart;
  logic       complete;
  logic       access;
  logic       wr_en;
  logic       rd;
  logic       ten_bit;
  logic       trig_rise;
  logic       start;
  logic       abort;
  logic       stop_kill;
  logic [5:0] samp_last;
  logic [7:0] rbyte;
  logic       mapped;

  // Trigger, alternate and async clocks come from other domains
  adcrc_sync #(
    .W (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({async_clk, alt_clk, hw_trigger}),
    .q       (pins_s)
  );

  adcrc_divider u_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .in_tick    (in_tick),
    .ratio_code (st_q.div),
    .restart    (restart),
    .half_tick  (half_tick),
    .conv_clk   (conv_clk)
  );

  // Bus clock counts one half period per cycle, others per edge
  always_comb begin
    if (st_q.aclk) begin
      in_tick = pins_s[2] ^ st_q.pins_d[2];
    end else if (st_q.ics) begin
      in_tick = 1'b1;
    end else begin
      in_tick = pins_s[1] ^ st_q.pins_d[1];
    end
  end

  // Bus decode; transfer completes on the second access cycle
  assign access  = psel & penable & st_q.ready;
  assign wr_en   = access & pwrite & pstrb[0];
  assign rd      = access & ~pwrite;
  assign ten_bit = st_q.mode != adcrc_pkg::MODE_8_SW;
  assign trig_rise = pins_s[0] & ~st_q.pins_d[0];
  assign samp_last = (st_q.lsmp ? adcrc_pkg::SAMPLE_LONG_HALF
                                : adcrc_pkg::SAMPLE_SHORT_HALF) - 6'h01;
  assign stop_kill = stop_mode & ~st_q.aclk;

  // Start and abort requests
  always_comb begin
    start = 1'b0;
    abort = stop_kill;
    if (wr_en && paddr == adcrc_pkg::OFS_STATUS_CONTROL) begin
      // control write aborts and may restart
      abort = 1'b1;
      // software trigger only in software modes
      start = st_q.mode != adcrc_pkg::MODE_10_HW &&
              pwdata[4:0] != adcrc_pkg::CHAN_OFF && !stop_kill;
    // external trigger starts in hardware mode
    end else if (st_q.mode == adcrc_pkg::MODE_10_HW && trig_rise &&
                 st_q.state == adcrc_pkg::ST_IDLE &&
                 st_q.chan != adcrc_pkg::CHAN_OFF && !stop_kill) begin
      start = 1'b1;
    end
  end

  // Read data mux for the current address
  always_comb begin
    rbyte  = 8'h00;
    mapped = 1'b1;
    case (paddr)
      adcrc_pkg::OFS_STATUS_CONTROL: rbyte = {st_q.done, st_q.aien,
                                              st_q.cont, st_q.chan};
      // unused high bits read as zero
      adcrc_pkg::OFS_RESULT_HIGH:    rbyte = {6'h00, st_q.res_hi};
      adcrc_pkg::OFS_RESULT_LOW:     rbyte = st_q.res_lo;
      adcrc_pkg::OFS_CLOCK_MODE:     rbyte = {st_q.lpc, st_q.div, st_q.ics,
                                              st_q.mode, st_q.lsmp,
                                              st_q.aclk};
      adcrc_pkg::OFS_IRQ_STATUS:     rbyte = {7'h00, st_q.irq_stat};
      adcrc_pkg::OFS_IRQ_MASK:       rbyte = {7'h00, st_q.irq_mask};
      default:                       mapped = 1'b0;
    endcase
  end

  // Main next state
  always_comb begin
    st_d        = st_q;
    restart     = 1'b0;
    complete    = 1'b0;
    st_d.pins_d = pins_s;
    // Bus handshake: one wait state, then answer
    st_d.ready  = psel & penable & ~st_q.ready;
    st_d.rdata  = {24'h00_0000, rbyte};
    st_d.err    = ~mapped;
    // Register writes
    if (wr_en) begin
      case (paddr)
        adcrc_pkg::OFS_STATUS_CONTROL: begin
          st_d.aien = pwdata[adcrc_pkg::SCR_AIEN_BIT];
          st_d.cont = pwdata[adcrc_pkg::SCR_CONT_BIT];
          st_d.chan = pwdata[adcrc_pkg::SCR_CHAN_LSB +: 5];
          st_d.done = 1'b0;
        end
        adcrc_pkg::OFS_CLOCK_MODE: begin
          st_d.lpc  = pwdata[adcrc_pkg::CLK_LPC_BIT];
          st_d.div  = pwdata[adcrc_pkg::CLK_DIV_LSB +: 2];
          st_d.ics  = pwdata[adcrc_pkg::CLK_ICS_BIT];
          st_d.mode = pwdata[adcrc_pkg::CLK_MODE_LSB +: 2];
          st_d.lsmp = pwdata[adcrc_pkg::CLK_LSMP_BIT];
          st_d.aclk = pwdata[adcrc_pkg::CLK_ACLK_BIT];
          // clock mode write ends continuous mode
          st_d.cont = 1'b0;
          if (pwdata[adcrc_pkg::CLK_MODE_LSB +: 2] ==
              adcrc_pkg::MODE_8_SW) begin
            st_d.locked = 1'b0;
          end
        end
        adcrc_pkg::OFS_IRQ_STATUS: begin
          if (pwdata[0]) begin
            st_d.irq_stat = 1'b0;
          end
        end
        adcrc_pkg::OFS_IRQ_MASK:   st_d.irq_mask = pwdata[0];
        default: ;
      endcase
    end
    // ten-bit high read arms the interlock
    if (rd && paddr == adcrc_pkg::OFS_RESULT_HIGH && ten_bit) begin
      st_d.locked = 1'b1;
    end
    // low read clears flag and pending interrupt
    if (rd && paddr == adcrc_pkg::OFS_RESULT_LOW) begin
      st_d.locked   = 1'b0;
      st_d.done     = 1'b0;
      st_d.irq_stat = 1'b0;
    end
    // stop without async clock ends continuous runs
    if (stop_kill) begin
      st_d.cont = 1'b0;
    end
    // Sequencer; abort wins over any step in progress
    if (abort || start) begin
      st_d.state = start ? adcrc_pkg::ST_SAMPLE : adcrc_pkg::ST_IDLE;
      st_d.cnt   = '0;
      restart    = 1'b1;
    end else if (half_tick) begin
      case (st_q.state)
        adcrc_pkg::ST_SAMPLE: begin
          // sample phase length in half periods
          if (st_q.cnt == samp_last) begin
            st_d.state = adcrc_pkg::ST_CONVERT;
            st_d.cnt   = '0;
          end else begin
            st_d.cnt = st_q.cnt + 6'h01;
          end
        end
        adcrc_pkg::ST_CONVERT: begin
          if (st_q.cnt == adcrc_pkg::CONVERT_HALF - 6'h01) begin
            complete   = 1'b1;
            st_d.cnt   = '0;
            st_d.state = st_q.cont ? adcrc_pkg::ST_SAMPLE
                                   : adcrc_pkg::ST_IDLE;
          end else begin
            st_d.cnt = st_q.cnt + 6'h01;
          end
        end
        default: st_d.state = adcrc_pkg::ST_IDLE;
      endcase
    end
    // Completion; set wins over a same-cycle clear
    if (complete) begin
      if (!(ten_bit && st_q.locked)) begin
        // upper bits, zero in eight-bit mode
        st_d.res_hi = ten_bit ? core_result[9:8] : 2'h0;
        st_d.res_lo = core_result[7:0];
      end
      st_d.done = 1'b1;
      if (st_q.aien) begin
        st_d.irq_stat = 1'b1;
      end
    end
    // Registered core controls
    st_d.sample  = st_d.state == adcrc_pkg::ST_SAMPLE;
    st_d.convert = st_d.state == adcrc_pkg::ST_CONVERT;
    // async generator runs only while sampling or converting
    st_d.osc_en  = st_d.state != adcrc_pkg::ST_IDLE && st_d.aclk;
    st_d.irq     = st_d.irq_stat & st_d.irq_mask;
    st_d.ten     = st_d.mode != adcrc_pkg::MODE_8_SW;
  end

  // State register; mode resets to eight-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q       <= '0;
      st_q.chan  <= adcrc_pkg::RST_CHAN;
      st_q.div   <= adcrc_pkg::RST_DIV;
      st_q.mode  <= adcrc_pkg::RST_MODE;
      st_q.state <= adcrc_pkg::ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flops
  assign prdata         = st_q.rdata;
  assign pready         = st_q.ready;
  assign pslverr        = st_q.err;
  assign core_channel   = st_q.chan;
  assign core_sample    = st_q.sample;
  assign core_convert   = st_q.convert;
  assign core_low_power = st_q.lpc;
  assign core_ten_bit   = st_q.ten;
  assign async_osc_en   = st_q.osc_en;
  assign irq            = st_q.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_high_load: assert property (complete && !(ten_bit && st_q.locked)
    |=> st_q.res_hi == ($past(ten_bit) ? $past(core_result[9:8]) : 2'h0))
    else $error("high result not loaded");
  a_low_load: assert property (complete && !(ten_bit && st_q.locked)
    |=> st_q.res_lo == $past(core_result[7:0]))
    else $error("low result not loaded");
  a_lock_arm: assert property (rd && paddr == adcrc_pkg::OFS_RESULT_HIGH
    && ten_bit && !(paddr == adcrc_pkg::OFS_RESULT_LOW) |=> st_q.locked)
    else $error("interlock not armed");
  a_lock_drop: assert property (complete && ten_bit && st_q.locked
    |=> $stable(st_q.res_lo) && $stable(st_q.res_hi))
    else $error("locked result overwritten");
  a_eight_nolock: assert property (complete && !ten_bit
    |=> st_q.res_lo == $past(core_result[7:0]))
    else $error("eight-bit result blocked");
  a_lpc_write: assert property (wr_en && paddr == adcrc_pkg::OFS_CLOCK_MODE
    |=> core_low_power == $past(pwdata[7]))
    else $error("low power bit not applied");
  a_sample_len: assert property (st_q.state == adcrc_pkg::ST_SAMPLE &&
    st_d.state == adcrc_pkg::ST_CONVERT |-> st_q.cnt == samp_last)
    else $error("sample phase length wrong");
  a_osc_idle: assert property (st_q.state == adcrc_pkg::ST_IDLE [*2]
    |-> !async_osc_en)
    else $error("async clock runs while idle");
  a_stop_kill: assert property (stop_kill |=> !st_q.cont &&
    st_q.state == adcrc_pkg::ST_IDLE)
    else $error("conversion continues in stop");
  a_low_clear: assert property (rd && paddr == adcrc_pkg::OFS_RESULT_LOW
    && !complete |=> !st_q.done && !st_q.irq_stat && !irq)
    else $error("low read did not clear flag");
  a_sw_start: assert property (start |=> core_sample [*1]
    ##0 st_q.cnt == 6'h00)
    else $error("start did not begin sampling");
  a_cont_end: assert property (wr_en && paddr == adcrc_pkg::OFS_CLOCK_MODE
    |=> !st_q.cont)
    else $error("continuous mode survives clock write");
endmodule
`default_nettype wire

// File: adcrc_core_model.sv
// Behavioural analog converter core facing the result and clock control
`timescale 1ns/100ps
`default_nettype none
module adcrc_core_model (
  // Clock
  input  wire logic       pclk,
  // Phase controls from the block
  input  wire logic       core_sample,
  input  wire logic       core_convert,
  // Value the bench wants converted
  input  wire logic [9:0] next_value,
  // Result to the block
  output logic      [9:0] core_result
);
  logic [9:0] held;

  // Non zero start so a stale zero never passes for a result
  initial begin
    held = 10'h2A5;
    core_result = 10'h15A;
  end

  // Capture while sampling, hold through convert, otherwise toggle
  // every cycle so a late load never sees a settled value
  always @(posedge pclk) begin
    if (core_sample === 1'h1)
      held <= next_value;
    core_result <= (core_convert === 1'h1) ? held : ~core_result;
  end
endmodule
`default_nettype wire

// File: adcrc_top_tb_top.sv
// Self-checking bench for the converter result and clock control
`timescale 1ns/100ps
`default_nettype none
module adcrc_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic        stop_mode, hw_trigger, alt_clk, async_clk, irq;
  logic [9:0]  core_result, next_value, va, vb;
  logic [4:0]  core_channel;
  logic        core_sample, core_convert, core_low_power, core_ten_bit;
  logic        async_osc_en, conv_clk;
  logic [32:0] exp_q[$];
  logic [15:0] seed;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  int          n, m, t;
  logic        p;

  adcrc_top i_adcrc_top (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr, .stop_mode,
    .hw_trigger, .alt_clk, .async_clk, .core_result, .core_channel,
    .core_sample, .core_convert, .core_low_power, .core_ten_bit,
    .async_osc_en, .conv_clk, .irq);

  adcrc_core_model i_adcrc_core_model (.pclk, .core_sample,
    .core_convert, .next_value, .core_result);

  // Bus clock
  initial pclk = 1'h0;
  always #20 pclk = ~pclk;

  // Alternate clock runs free; the async clock runs only when enabled,
  // as the real generator does, so a stuck enable starves the block
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles % 2 == 0)
      alt_clk <= ~alt_clk;
    if (async_osc_en === 1'h1 && cycles % 3 == 0)
      async_clk <= ~async_clk;
    if (cycles == 40000) begin
      bad_count++;
      conclude();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read answers are taken at the edge where pready is sampled high
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'h1 && !pwrite) begin
      chk("prdata", exp_q[0][31:0], prdata);
      chk("pslverr", 32'(exp_q[0][32]), 32'(pslverr));
      void'(exp_q.pop_front());
    end
  end

  // One APB transfer; request held until pready is seen at an edge
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic [3:0] st,
                      input logic [32:0] e);
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'h1;
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'h1, d, 4'hF, 33'h0_0000_0000);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'h0, 32'h0000_0000, 4'hF, {1'h0, e});
  endtask

  // Phase lengths of one conversion; zero skips the length check
  task automatic conv(input int es, input int ec);
    n = 0;
    m = 0;
    t = 0;
    while (core_sample !== 1'h1 && core_convert !== 1'h1)
      @(negedge pclk);
    while (core_sample === 1'h1) begin
      n++;
      p = conv_clk;
      @(negedge pclk);
    end
    while (core_convert !== 1'h1)
      @(negedge pclk);
    // Each convert half period shows as one conversion clock edge
    while (core_convert === 1'h1) begin
      m++;
      t += int'(conv_clk !== p);
      p = conv_clk;
      @(negedge pclk);
    end
    if (es > 0) chk("sample_len", es, n);
    if (ec > 0) chk("convert_len", ec, m);
    chk("conv_clk_edges", 32'(adcrc_pkg::CONVERT_HALF), t);
  endtask

  // Cycles of sampling seen in a window; used to prove no start
  task automatic quiet();
    n = 0;
    repeat (60) begin
      @(negedge pclk);
      n += int'(core_sample === 1'h1);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, stop_mode, hw_trigger} = 6'h00;
    {alt_clk, async_clk} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    next_value = 10'h000;
    seed = 16'h0046;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    chk("core_channel", 32'h0000_001F, 32'(core_channel));
    rd(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0000);
    rd(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_001F);
    xfer(8'h1C, 1'h0, 32'h0, 4'hF, 33'h1_0000_0000);
    xfer(adcrc_pkg::OFS_CLOCK_MODE, 1'h1, 32'h0000_00FF, 4'h0, 33'h0);
    rd(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0000);
    // power and mode fields reach the core
    for (int k = 0; k < 4; k++) begin
      wr(adcrc_pkg::OFS_CLOCK_MODE, {24'h0, k[0], 3'h1, k[1:0], 2'h0});
      rd(adcrc_pkg::OFS_CLOCK_MODE, {24'h0, k[0], 3'h1, k[1:0], 2'h0});
      chk("low_power", 32'(k[0]), 32'(core_low_power));
      chk("ten_bit", 32'(k != 0), 32'(core_ten_bit));
    end
    // bus clock ratios, long sample, 8-bit results
    for (int r = 0; r < 5; r++) begin
      wr(adcrc_pkg::OFS_CLOCK_MODE, (r == 4) ? 32'h12 : 32'h10 | (r << 5));
      seed = lfsr(seed);
      next_value <= seed[9:0];
      rd(adcrc_pkg::OFS_RESULT_HIGH, 32'h0000_0000);
      wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0003);
      conv((r == 4) ? 47 : 7 << r, (r == 4) ? 20 : 20 << r);
      rd(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0083);
      rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, seed[7:0]});
      rd(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0003);
    end
    // ten-bit interlock drops the middle result
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0014);
    va = seed[15:6];
    vb = ~seed[9:0];
    next_value <= va;
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    conv(7, 20);
    rd(adcrc_pkg::OFS_RESULT_HIGH, {30'h0, va[9:8]});
    next_value <= vb;
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    conv(0, 0);
    rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, va[7:0]});
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    conv(0, 0);
    rd(adcrc_pkg::OFS_RESULT_HIGH, {30'h0, vb[9:8]});
    rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, vb[7:0]});
    // interrupt raised, cleared by low read, masked, write one clear
    wr(adcrc_pkg::OFS_IRQ_MASK, 32'h0000_0001);
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0042);
    conv(0, 0);
    @(negedge pclk);
    chk("irq", 32'h0000_0001, 32'(irq));
    rd(adcrc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, vb[7:0]});
    rd(adcrc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(adcrc_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0042);
    conv(0, 0);
    repeat (2) @(negedge pclk);
    chk("irq", 32'h0000_0000, 32'(irq));
    rd(adcrc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    wr(adcrc_pkg::OFS_IRQ_STATUS, 32'h0000_0001);
    rd(adcrc_pkg::OFS_IRQ_STATUS, 32'h0000_0000);
    // hardware mode ignores writes, starts on the trigger pin
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_001C);
    next_value <= va;
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    quiet();
    chk("hw_no_start", 32'h0000_0000, 32'(n));
    hw_trigger <= 1'h1;
    repeat (4) @(posedge pclk);
    hw_trigger <= 1'h0;
    conv(0, 0);
    rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, va[7:0]});
    // alternate clock, two cycles per half period
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0004);
    // Known alternate clock phase, so the first half period is whole
    @(posedge pclk iff (cycles % 2 == 0));
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    conv(14, 40);
    // async clock keeps converting in stop, runs only while busy
    stop_mode <= 1'h1;
    next_value <= vb;
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0005);
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    repeat (5) @(negedge pclk);
    chk("osc_on", 32'h0000_0001, 32'(async_osc_en));
    conv(0, 0);
    repeat (2) @(negedge pclk);
    chk("osc_off", 32'h0000_0000, 32'(async_osc_en));
    rd(adcrc_pkg::OFS_RESULT_LOW, {24'h0, vb[7:0]});
    // stop without async clock aborts and ends continuous mode
    stop_mode <= 1'h0;
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0014);
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0022);
    repeat (3) @(posedge pclk);
    stop_mode <= 1'h1;
    repeat (4) @(posedge pclk);
    stop_mode <= 1'h0;
    quiet();
    chk("stop_abort", 32'h0000_0000, 32'(n));
    rd(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0002);
    // clock mode write ends continuous, channel off never starts
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_0022);
    conv(7, 20);
    conv(7, 20);
    wr(adcrc_pkg::OFS_CLOCK_MODE, 32'h0000_0014);
    repeat (40) @(negedge pclk);
    quiet();
    chk("cont_end", 32'h0000_0000, 32'(n));
    wr(adcrc_pkg::OFS_STATUS_CONTROL, 32'h0000_001F);
    quiet();
    chk("chan_off", 32'h0000_0000, 32'(n));
    conclude();
  end
endmodule
`default_nettype wire
